// *** logic/mcmts_pkg.sv ***
// constants, types and helpers shared by the memory test sequencer
`default_nettype none
package mcmts_pkg;

  // channel population: four sram channels first, then two ddr channels
  localparam int NUM_SRAM = 4;
  localparam int NUM_DDR  = 2;

  // clock of this block and the controller user clocks that the channels face
  localparam int MCLK_HZ           = 10_000_000;
  localparam int SRAM_MEM_CLK_KHZ  = 550_000;
  localparam int SRAM_USER_CLK_KHZ = 275_000;
  localparam int DDR_USER_CLK_KHZ  = 266_667;

  // memory sizes: sram word-address width, ddr space in bytes as a power of two
  localparam int SRAM_ADDR_W_DEF  = 21;
  localparam int DDR_SPACE_LOG2   = 32;
  localparam int DATA_W_DEF       = 32;

  // timing: ddr test window and blink half period
  localparam int TEST_WINDOW_MS   = 2000;
  localparam int TEST_WINDOW_CYC  = TEST_WINDOW_MS * (MCLK_HZ / 1000);
  localparam int BLINK_HALF_MS    = 250;
  localparam int BLINK_HALF_CYC   = BLINK_HALF_MS * (MCLK_HZ / 1000);

  // register map (byte addresses) on the axi4-lite port
  localparam int         AXI_ADDR_W = 8;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CLEAR  = 8'h04;
  localparam logic [7:0] REG_ENABLE = 8'h08;
  localparam logic [7:0] REG_CTRL   = 8'h0C;
  localparam logic [7:0] REG_RESULT = 8'h10;

  // field layout: status/enable/clear hold done[5:0] and fail[11:6]
  localparam int EVT_W        = 12;
  localparam int EVT_FAIL_LSB = 6;
  localparam int CTRL_START   = 0;
  localparam int RES_FAIL_LSB = 6;
  localparam int RES_BUSY_LSB = 12;
  localparam int RES_VIEW_BIT = 18;
  localparam logic [EVT_W-1:0] ENABLE_RST = 12'h000;

  // bus responses and pattern seed
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam logic [31:0] PATTERN_SEED = 32'hACE1_5A3C;

  // per-channel sequencer phases
  typedef enum logic [1:0] {CH_IDLE, CH_WRITE, CH_READ, CH_DONE} mcmts_chan_t;

  // galois lfsr step, x^32+x^22+x^2+x+1
  function automatic logic [31:0] mcmts_lfsr(input logic [31:0] v);
    mcmts_lfsr = v[0] ? ((v >> 1) ^ 32'h8020_0003) : (v >> 1);
  endfunction : mcmts_lfsr

  // expand byte strobes into a bit mask
  function automatic logic [31:0] mcmts_mask(input logic [3:0] s);
    mcmts_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : mcmts_mask

endpackage : mcmts_pkg
`default_nettype wire

// *** logic/mcmts_top.sv ***
// multi-channel memory test sequencer with axi4-lite status and interrupt
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - write whole address space before any read
// - regenerate write sequence, compare every read word
// - each channel uses its own controller port
// - sram starts derive from restart button
// - restart held drives sram indicators off
// - passing sram channel lights its indicator
// - dark sram indicator after release means failure
// - indicators zero..three map sram A..D
// - each press relaunches a complete run
// - sram channels sized for half-rate user port
// - ddr channels quarter-rate, 4 GB space each
// - ddr start makes ddr and alive indicators blink
// - after window passing ddr indicator stays on
// - ddr indicator off after window means failure
// - alive indicator blinks from the block clock
// - ddr blinking only after calibration success
module mcmts_top #(
  parameter int          SRAM_ADDR_W        = mcmts_pkg::SRAM_ADDR_W_DEF,
  parameter int          DATA_W             = mcmts_pkg::DATA_W_DEF,
  parameter int unsigned TEST_WINDOW_CYCLES = mcmts_pkg::TEST_WINDOW_CYC,
  parameter int unsigned BLINK_HALF_CYCLES  = mcmts_pkg::BLINK_HALF_CYC,
  parameter int          DDR_ADDR_W         = mcmts_pkg::DDR_SPACE_LOG2 - $clog2(DATA_W / 8),
  parameter int          ADDR_W             = (SRAM_ADDR_W > DDR_ADDR_W) ? SRAM_ADDR_W : DDR_ADDR_W,
  parameter int          NCH                = mcmts_pkg::NUM_SRAM + mcmts_pkg::NUM_DDR
) (
  input  wire logic                                 mclk,
  input  wire logic                                 rst_b,
  input  wire logic                                 ce,
  input  wire logic                                 restartButton_b,
  input  wire logic                                 ddrStartButton_b,
  input  wire logic [mcmts_pkg::NUM_DDR-1:0]         calSuccess,
  output logic      [NCH-1:0][ADDR_W-1:0]            memAddress,
  output logic      [NCH-1:0]                        memWrite,
  output logic      [NCH-1:0]                        memRead,
  output logic      [NCH-1:0][DATA_W-1:0]            memWriteData,
  input  wire logic [NCH-1:0]                        memWaitRequest,
  input  wire logic [NCH-1:0][DATA_W-1:0]            memReadData,
  input  wire logic [NCH-1:0]                        memReadDataValid,
  output logic                                      resultIndicatorA,
  output logic                                      resultIndicatorB,
  output logic                                      resultIndicatorC,
  output logic                                      resultIndicatorDOrClockAlive,
  output logic                                      irq,
  input  wire logic [mcmts_pkg::AXI_ADDR_W-1:0]      s_axi_awaddr,
  input  wire logic                                 s_axi_awvalid,
  output logic                                      s_axi_awready,
  input  wire logic [31:0]                          s_axi_wdata,
  input  wire logic [3:0]                           s_axi_wstrb,
  input  wire logic                                 s_axi_wvalid,
  output logic                                      s_axi_wready,
  output logic      [1:0]                           s_axi_bresp,
  output logic                                      s_axi_bvalid,
  input  wire logic                                 s_axi_bready,
  input  wire logic [mcmts_pkg::AXI_ADDR_W-1:0]      s_axi_araddr,
  input  wire logic                                 s_axi_arvalid,
  output logic                                      s_axi_arready,
  output logic      [31:0]                          s_axi_rdata,
  output logic      [1:0]                           s_axi_rresp,
  output logic                                      s_axi_rvalid,
  input  wire logic                                 s_axi_rready
);
  import mcmts_pkg::*;

  // last word address per channel type; sram sized for the half-rate port
  localparam logic [ADDR_W-1:0] SRAM_LAST = ADDR_W'((64'd1 << SRAM_ADDR_W) - 64'd1);
  localparam logic [ADDR_W-1:0] DDR_LAST  = ADDR_W'((64'd1 << DDR_ADDR_W) - 64'd1);
  localparam int                REP       = DATA_W / 32;

  // whole state of the block in one register
  typedef struct packed {
    logic [1:0]                   rstSync;    // restart button synchroniser
    logic [1:0]                   ddrSync;    // ddr start button synchroniser
    logic                         rstLast;    // previous synced restart level
    logic                         ddrLast;    // previous synced ddr start level
    logic                         ddrView;    // indicators show the ddr run
    mcmts_chan_t [NCH-1:0]        st;         // channel phase
    logic [NCH-1:0][ADDR_W-1:0]   addr;       // request address
    logic [NCH-1:0][ADDR_W-1:0]   chkAddr;    // address of next returned word
    logic [NCH-1:0][31:0]         genLfsr;    // pattern for issued writes
    logic [NCH-1:0][31:0]         chkLfsr;    // pattern for returned reads
    logic [NCH-1:0]               wr;         // write request held
    logic [NCH-1:0]               rd;         // read request held
    logic [NCH-1:0]               fail;       // sticky mismatch
    logic [NCH-1:0]               pass;       // run finished clean
    logic [NCH-1:0]               pend;       // start waiting on calibration
    logic [31:0]                  winCnt;     // ddr window counter
    logic                         winDone;    // ddr window elapsed
    logic [31:0]                  blinkCnt;   // blink divider
    logic                         blink;      // blink phase
    logic [3:0]                   led;        // indicator drive
    logic [EVT_W-1:0]             status;     // sticky events
    logic [EVT_W-1:0]             irqEn;      // interrupt enables
    logic                         irq;        // interrupt level
    logic                         awHeld;     // write address captured
    logic                         wHeld;      // write data captured
    logic [AXI_ADDR_W-1:0]        awAddr;
    logic [31:0]                  wData;
    logic [3:0]                   wStrb;
    logic                         awReady;
    logic                         wReady;
    logic                         bValid;
    logic [1:0]                   bResp;
    logic                         arReady;
    logic                         rValid;
    logic [31:0]                  rData;
    logic [1:0]                   rResp;
  } mcmts_state_t;

  mcmts_state_t q;                 // registered state
  mcmts_state_t d;                 // next state
  logic [NCH-1:0] chStart;         // channel launch this cycle
  logic           ddrPress;        // falling edge of the ddr start button
  logic           sramHeld;        // restart button held down
  logic           swStart;         // software start written to control

  // outputs straight from the state register; one port per controller
  assign memAddress    = q.addr;
  assign memWrite      = q.wr;
  assign memRead       = q.rd;
  assign resultIndicatorA             = q.led[0];
  assign resultIndicatorB             = q.led[1];
  assign resultIndicatorC             = q.led[2];
  assign resultIndicatorDOrClockAlive = q.led[3];
  assign irq           = q.irq;
  assign s_axi_awready = q.awReady;
  assign s_axi_wready  = q.wReady;
  assign s_axi_bresp   = q.bResp;
  assign s_axi_bvalid  = q.bValid;
  assign s_axi_arready = q.arReady;
  assign s_axi_rdata   = q.rData;
  assign s_axi_rresp   = q.rResp;
  assign s_axi_rvalid  = q.rValid;

  // write data is the generator word, widened by replication
  for (genvar g = 0; g < NCH; g++) begin : gen_wdata
    assign memWriteData[g] = {REP{q.genLfsr[g]}};
  end

  // next-state logic for buttons, channels, indicators and the bus slave
  always_comb begin
    logic [ADDR_W-1:0]  last;
    logic [31:0]        seed;
    logic               miss;
    logic               ddrOn;
    logic [EVT_W-1:0]   evt;
    logic [EVT_W-1:0]   clr;
    logic [31:0]        mask;
    logic               wrOk;
    last  = '0;
    seed  = '0;
    miss  = 1'b0;
    ddrOn = 1'b0;
    evt   = '0;
    clr   = '0;
    mask  = '0;
    wrOk  = 1'b0;
    d       = q;
    swStart = 1'b0;
    chStart = '0;

    // buttons: only the second stage is looked at
    d.rstSync = {q.rstSync[0], restartButton_b};
    d.ddrSync = {q.ddrSync[0], ddrStartButton_b};
    d.rstLast = q.rstSync[1];
    d.ddrLast = q.ddrSync[1];
    sramHeld  = !q.rstSync[1];
    ddrPress  = q.ddrLast && !q.ddrSync[1];

    // axi write: capture address and data in either order
    if (q.bValid && s_axi_bready) begin
      d.bValid = 1'b0;
    end
    if (s_axi_awvalid && q.awReady) begin
      d.awHeld = 1'b1;
      d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wReady) begin
      d.wHeld = 1'b1;
      d.wData = s_axi_wdata;
      d.wStrb = s_axi_wstrb;
    end
    if (q.awHeld && q.wHeld && !q.bValid) begin
      mask = mcmts_mask(q.wStrb);
      wrOk = 1'b1;
      case (q.awAddr)
        REG_CLEAR:  clr = q.wData[EVT_W-1:0] & mask[EVT_W-1:0];
        REG_ENABLE: d.irqEn = (q.irqEn & ~mask[EVT_W-1:0]) | (q.wData[EVT_W-1:0] & mask[EVT_W-1:0]);
        REG_CTRL:   swStart = q.wData[CTRL_START] && q.wStrb[0];
        REG_STATUS, REG_RESULT: wrOk = 1'b1; // read-only, write ignored
        default:    wrOk = 1'b0;
      endcase
      d.bValid = 1'b1;
      d.bResp  = wrOk ? RESP_OKAY : RESP_SLVERR;
      d.awHeld = 1'b0;
      d.wHeld  = 1'b0;
    end
    d.awReady = !d.awHeld && !d.bValid;
    d.wReady  = !d.wHeld && !d.bValid;

    // sram view on restart press, ddr view on ddr start press
    if (!q.rstSync[1] && q.rstLast) begin
      d.ddrView = 1'b0;
    end
    if (ddrPress) begin
      d.ddrView = 1'b1;
      d.winCnt  = '0;
      d.winDone = 1'b0;
    end else if (!q.winDone) begin
      d.winCnt  = q.winCnt + 32'd1;
      d.winDone = (q.winCnt == 32'(TEST_WINDOW_CYCLES - 1));
    end

    // per-channel sequencers
    for (int i = 0; i < NCH; i++) begin
      last = (i < NUM_SRAM) ? SRAM_LAST : DDR_LAST;
      seed = PATTERN_SEED ^ 32'(i);
      if (i < NUM_SRAM) begin
        // release of restart, or software start while not held
        chStart[i] = !sramHeld && ((q.rstSync[1] && !q.rstLast) || swStart);
      end else begin
        // ddr press arms the channel; launch waits for calibration
        if (ddrPress || swStart) begin
          d.pend[i] = 1'b1;
        end
        chStart[i] = d.pend[i] && calSuccess[i-NUM_SRAM];
      end

      if (i < NUM_SRAM && sramHeld) begin
        // held button parks the sram channel and clears its result
        d.st[i]   = CH_IDLE;
        d.wr[i]   = 1'b0;
        d.rd[i]   = 1'b0;
        d.fail[i] = 1'b0;
        d.pass[i] = 1'b0;
      end else if (chStart[i]) begin
        // fresh run: write phase from address zero, seeded generator
        d.st[i]      = CH_WRITE;
        d.addr[i]    = '0;
        d.chkAddr[i] = '0;
        d.genLfsr[i] = seed;
        d.wr[i]      = 1'b1;
        d.rd[i]      = 1'b0;
        d.fail[i]    = 1'b0;
        d.pass[i]    = 1'b0;
        d.pend[i]    = 1'b0;
      end else if (i >= NUM_SRAM && ddrPress) begin
        // pending on calibration: hold idle, result cleared
        d.st[i]   = CH_IDLE;
        d.wr[i]   = 1'b0;
        d.rd[i]   = 1'b0;
        d.fail[i] = 1'b0;
        d.pass[i] = 1'b0;
      end else begin
        case (q.st[i])
          CH_WRITE: begin
            // a request is taken when waitrequest is low
            if (q.wr[i] && !memWaitRequest[i]) begin
              if (q.addr[i] == last) begin
                d.wr[i]      = 1'b0;
                d.st[i]      = CH_READ;
                d.addr[i]    = '0;
                d.rd[i]      = 1'b1;
                d.chkLfsr[i] = seed;
              end else begin
                d.addr[i]    = q.addr[i] + ADDR_W'(1);
                d.genLfsr[i] = mcmts_lfsr(q.genLfsr[i]);
              end
            end
          end
          CH_READ: begin
            // issue side walks addresses while replies stream back
            if (q.rd[i] && !memWaitRequest[i]) begin
              if (q.addr[i] == last) begin
                d.rd[i] = 1'b0;
              end else begin
                d.addr[i] = q.addr[i] + ADDR_W'(1);
              end
            end
            if (memReadDataValid[i]) begin
              miss = (memReadData[i] != {REP{q.chkLfsr[i]}});
              if (miss) begin
                d.fail[i] = 1'b1;
              end
              if (q.chkAddr[i] == last) begin
                d.st[i]   = CH_DONE;
                d.pass[i] = !(q.fail[i] || miss);
                evt[i]    = 1'b1;
                evt[EVT_FAIL_LSB+i] = q.fail[i] || miss;
              end else begin
                d.chkAddr[i] = q.chkAddr[i] + ADDR_W'(1);
                d.chkLfsr[i] = mcmts_lfsr(q.chkLfsr[i]);
              end
            end
          end
          CH_DONE:  d.st[i] = CH_DONE;
          CH_IDLE:  d.st[i] = CH_IDLE;
          default:  d.st[i] = CH_IDLE;
        endcase
      end
    end

    // blink divider runs from the block clock, so a dead clock shows steady
    if (q.blinkCnt == 32'(BLINK_HALF_CYCLES - 1)) begin
      d.blinkCnt = '0;
      d.blink    = !q.blink;
    end else begin
      d.blinkCnt = q.blinkCnt + 32'd1;
    end

    // indicators
    if (!d.ddrView) begin
      for (int k = 0; k < NUM_SRAM; k++) begin
        // dark while held; afterwards dark also means a failed run
        d.led[k] = !sramHeld && d.pass[k];
      end
    end else begin
      d.led[0] = 1'b0;
      for (int k = 0; k < NUM_DDR; k++) begin
        ddrOn = (d.pend[NUM_SRAM+k] || d.st[NUM_SRAM+k] != CH_IDLE) && calSuccess[k];
        // after the window only a passing channel stays lit
        d.led[1+k] = d.winDone ? d.pass[NUM_SRAM+k]
                               : (ddrOn && d.blink);
      end
      d.led[3] = d.blink;
    end

    // sticky events: a set in the same cycle as its clear wins
    d.status = (q.status & ~clr) | evt;
    d.irq    = |(d.status & d.irqEn);

    // axi read: one outstanding, answered the cycle after the address
    if (q.rValid && s_axi_rready) begin
      d.rValid = 1'b0;
    end
    if (s_axi_arvalid && q.arReady) begin
      d.rValid = 1'b1;
      d.rResp  = RESP_OKAY;
      d.rData  = '0;
      case (s_axi_araddr)
        REG_STATUS: d.rData[EVT_W-1:0] = q.status;
        REG_ENABLE: d.rData[EVT_W-1:0] = q.irqEn;
        REG_CLEAR, REG_CTRL: d.rData = '0;
        REG_RESULT: begin
          for (int k = 0; k < NCH; k++) begin
            d.rData[k]              = q.pass[k];
            d.rData[RES_FAIL_LSB+k] = q.fail[k];
            d.rData[RES_BUSY_LSB+k] = (q.st[k] == CH_WRITE) || (q.st[k] == CH_READ);
          end
          d.rData[RES_VIEW_BIT] = q.ddrView;
        end
        default: d.rResp = RESP_SLVERR;
      endcase
    end
    d.arReady = !d.rValid;
  end

  // state register; clock enable freezes everything
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q         <= '0;
      q.rstSync <= 2'h3;
      q.ddrSync <= 2'h3;
      q.rstLast <= 1'b1;
      q.ddrLast <= 1'b1;
      q.irqEn   <= ENABLE_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  chk_sram_held_off: assert property (
    (ce && !q.rstSync[1]) |=> (q.ddrView || q.led == 4'h0))
    else $error("sram indicators lit while restart held");

  chk_sram_start_run: assert property (
    (ce && q.rstSync[1] && !q.rstLast) |=> (q.st[0] == CH_WRITE && q.addr[0] == '0))
    else $error("restart release did not launch sram write phase");

  chk_write_then_read: assert property (
    $rose(q.st[0] == CH_READ) |-> $past(q.wr[0] && !memWaitRequest[0] && q.addr[0] == SRAM_LAST))
    else $error("read phase entered before last write was taken");

  chk_read_reseeded: assert property (
    $rose(q.st[0] == CH_READ) |-> (q.chkLfsr[0] == PATTERN_SEED && q.addr[0] == '0 && q.rd[0]))
    else $error("read phase did not restart the pattern");

  chk_mismatch_caught: assert property (
    (ce && q.st[0] == CH_READ && memReadDataValid[0] && !sramHeld && !chStart[0]
      && memReadData[0] != {REP{q.chkLfsr[0]}}) |=> q.fail[0])
    else $error("read mismatch not flagged");

  chk_fail_sticky: assert property (
    (ce && q.fail[0] && !sramHeld && !chStart[0]) |=> q.fail[0])
    else $error("failure flag dropped before restart");

  chk_pass_led_on: assert property (
    (ce && !q.ddrView && !sramHeld && q.pass[0] && !ddrPress && !chStart[0]) |=> q.led[0])
    else $error("passing sram channel indicator dark");

  chk_ddr_cal_gate: assert property (
    (ce && q.ddrView && !calSuccess[0] && !q.pass[NUM_SRAM]) |=> !q.led[1])
    else $error("ddr indicator active without calibration");

  chk_ddr_steady_on: assert property (
    (ce && q.ddrView && q.winDone && q.pass[NUM_SRAM] && !ddrPress && !swStart
      && !(q.rstLast && !q.rstSync[1])) |=> q.led[1])
    else $error("passing ddr indicator not steady after window");

endmodule : mcmts_top
`default_nettype wire

// *** verif/mcmts_mem_model.sv ***
// behavioural controller user ports facing the sequencer, one small memory per channel
`timescale 1ns/1ps
`default_nettype none
module mcmts_mem_model #(
  parameter int NCH = 6,
  parameter int AW  = 3,
  parameter int DW  = 32
) (
  input  wire logic                   mclk,
  input  wire logic                   slow,
  input  wire logic [NCH-1:0]         corrupt,
  input  wire logic [NCH-1:0][AW-1:0] memAddress,
  input  wire logic [NCH-1:0]         memWrite,
  input  wire logic [NCH-1:0]         memRead,
  input  wire logic [NCH-1:0][DW-1:0] memWriteData,
  output logic      [NCH-1:0]         memWaitRequest,
  output logic      [NCH-1:0][DW-1:0] memReadData,
  output logic      [NCH-1:0]         memReadDataValid
);
  logic [DW-1:0] mem [NCH][2**AW]; // storage, separate per channel
  logic          tick = 1'b0;      // stall phase
  // slow mode stalls every other edge, so the sequencer must hold requests
  always_comb memWaitRequest = {NCH{slow & tick}};
  // one-cycle read latency; outside a valid word the bus shows changing junk
  always_ff @(posedge mclk) begin
    tick <= ~tick;
    for (int c = 0; c < NCH; c++) begin
      memReadDataValid[c] <= memRead[c] & ~memWaitRequest[c];
      memReadData[c]      <= ~memReadData[c];
      if (memWrite[c] & ~memWaitRequest[c]) mem[c][memAddress[c]] <= memWriteData[c];
      if (memRead[c] & ~memWaitRequest[c]) memReadData[c] <= mem[c][memAddress[c]] ^ {DW{corrupt[c]}};
    end
  end
endmodule : mcmts_mem_model
`default_nettype wire

// *** verif/testbench.sv ***
// self-checking bench for the memory test sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mcmts_pkg::*;
  localparam int NC = NUM_SRAM + NUM_DDR;
  logic mclk = 0, rst_b = 0, ce = 1, restartButton_b = 0, ddrStartButton_b = 1, slow = 0, pre;
  logic [1:0] calSuccess = 0, s_axi_bresp, s_axi_rresp, rs;
  logic [NC-1:0] corrupt = 0, memWrite, memRead, memWaitRequest, memReadDataValid;
  logic [NC-1:0][2:0] memAddress;
  logic [NC-1:0][31:0] memWriteData, memReadData;
  logic resultIndicatorA, resultIndicatorB, resultIndicatorC, resultIndicatorDOrClockAlive, irq;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd, pat;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [41:0] rows [4]; // address, expected data, expected response
  int errors = 0, comparisons = 0, cyc = 0, n;
  wire [3:0] leds = {resultIndicatorDOrClockAlive, resultIndicatorC, resultIndicatorB, resultIndicatorA};
  // free-running 10 MHz clock
  always #50 mclk = ~mclk;
  mcmts_top #(.SRAM_ADDR_W(3), .DDR_ADDR_W(3), .TEST_WINDOW_CYCLES(200), .BLINK_HALF_CYCLES(4)) dut (
    .mclk, .rst_b, .ce, .restartButton_b, .ddrStartButton_b, .calSuccess, .memAddress,
    .memWrite, .memRead, .memWriteData, .memWaitRequest, .memReadData, .memReadDataValid,
    .resultIndicatorA, .resultIndicatorB, .resultIndicatorC, .resultIndicatorDOrClockAlive, .irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  mcmts_mem_model #(.NCH(NC), .AW(3), .DW(32)) mm (.mclk, .slow, .corrupt, .memAddress, .memWrite,
    .memRead, .memWriteData, .memWaitRequest, .memReadData, .memReadDataValid);
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check
  // axi4-lite write; starts one edge late so no signal is assigned twice in a step
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 0;
  endtask : axiWrite
  // axi4-lite read
  task automatic axiRead(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 0;
  endtask : axiRead
  // give the button synchroniser time, then poll until no channel is busy
  task automatic waitRun();
    repeat (10) @(posedge mclk);
    do axiRead(REG_RESULT); while (rd[RES_BUSY_LSB +: 6] != 0);
  endtask : waitRun
  task automatic tally_and_finish();
    $display("comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // hang guard: whole run is well under a thousand cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      tally_and_finish();
    end
  end
  initial begin
    rows[0] = {REG_STATUS, 32'h0000_000F, RESP_OKAY};
    rows[1] = {REG_RESULT, 32'h0000_000F, RESP_OKAY};
    rows[2] = {REG_CLEAR, 32'h0000_0000, RESP_OKAY};
    rows[3] = {8'h14, 32'h0000_0000, RESP_SLVERR};
    repeat (5) @(posedge mclk);
    rst_b <= 1;
    repeat (5) @(posedge mclk);
    check(leds, 0);
    restartButton_b <= 1;
    waitRun();
    check(leds, 4'hF);
    for (int c = 0; c < NUM_SRAM; c++) begin
      pat = PATTERN_SEED ^ c;
      for (int k = 0; k < 8; k++) begin
        check(mm.mem[c][k], pat);
        pat = pat[0] ? ((pat >> 1) ^ 32'h8020_0003) : (pat >> 1);
      end
    end
    $display("test sram pass done");
    for (int i = 0; i < 4; i++) begin
      axiRead(rows[i][41:34]);
      check(rd, rows[i][33:2]);
      check(rs, rows[i][1:0]);
    end
    axiWrite(8'h14, 0);
    check(rs, RESP_SLVERR);
    $display("test registers done");
    // only done bit 0 enabled; other set bits must stay masked
    check(irq, 0);
    axiWrite(REG_ENABLE, 1);
    repeat (2) @(posedge mclk);
    check(irq, 1);
    axiWrite(REG_CLEAR, 1);
    repeat (2) @(posedge mclk);
    check(irq, 0);
    // byte strobes: only byte one of the enable word may change
    s_axi_wstrb <= 4'h2;
    axiWrite(REG_ENABLE, 32'h0000_0FFF);
    s_axi_wstrb <= 4'hF;
    axiRead(REG_ENABLE);
    check(rd, 32'h0000_0F01);
    $display("test interrupt done");
    // stalled ports and a bad read path on channels a and c
    slow <= 1;
    corrupt <= 6'h05;
    restartButton_b <= 0;
    repeat (6) @(posedge mclk);
    check(leds, 0);
    restartButton_b <= 1;
    waitRun();
    check(leds, 4'hA);
    axiRead(REG_STATUS);
    check(rd, 32'h0000_014F);
    check(irq, 1);
    $display("test sram fail done");
    // ddr a calibrated, ddr b not yet
    calSuccess <= 2'b01;
    ddrStartButton_b <= 0;
    repeat (20) @(posedge mclk);
    ddrStartButton_b <= 1;
    n = 0;
    repeat (20) begin
      pre = resultIndicatorDOrClockAlive;
      @(posedge mclk);
      #1 if (pre !== resultIndicatorDOrClockAlive) n++;
    end
    check(32'(n > 0), 1);
    repeat (300) @(posedge mclk);
    check(leds[2:0], 3'b010);
    // clock enable low freezes the blink along with all other state
    @(posedge mclk);
    ce <= 0;
    #1 pre = resultIndicatorDOrClockAlive;
    repeat (10) @(posedge mclk);
    check(resultIndicatorDOrClockAlive, pre);
    ce <= 1;
    // ddr b calibrates late, runs from the pending press, reads back corrupted data
    corrupt <= 6'h20;
    calSuccess <= 2'b11;
    waitRun();
    check(leds[2:0], 3'b010);
    check(rd, 32'h0004_095A);
    $display("test ddr done");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
